// [rtl/ctmr_map.svh]
// Register offsets, field positions, codes and reset values for the compact timer
// Overview of operation
// - Run bit one counts, zero stops timer
// - Run bit rising loads counter with zero
// - Run bit falling holds counter value
// - Run rising restores compare pin initial level
// - First control bits two..zero read zero
// - Mode codes: compare, PWM, timer/counter
// - Timer/counter mode leaves pin undriven
// - Compare A match: none, low, high, toggle
// - PWM pin: inactive, active, waveform
// - Initial level bit sets compare pin start
// - Initial level bit sets PWM active level
// - Invert bit inverts the output pin
// - Swap bit exchanges PWM duty and period
// - Clear source selects A or P clear outside PWM
// - Overflow clear only with P zero
// - Counter readable as two byte registers
// - Compare A held in two bytes
// - Compare P matches counter top byte
// - Low bytes pass through one shared buffer
// - Sixteen bit up counter on timer tick
// - Clear on A outside PWM raises no P flag
`ifndef CTMR_MAP_SVH
`define CTMR_MAP_SVH
`define CTMR_OFF_CTRL0   3'h0
`define CTMR_OFF_CTRL1   3'h1
`define CTMR_OFF_CNT_LO  3'h2
`define CTMR_OFF_CNT_HI  3'h3
`define CTMR_OFF_CMPA_LO 3'h4
`define CTMR_OFF_CMPA_HI 3'h5
`define CTMR_OFF_CMPP    3'h6
`define CTMR_RUN_BIT     3
`define CTMR_INIT_BIT    3
`define CTMR_INV_BIT     2
`define CTMR_SWAP_BIT    1
`define CTMR_CLR_BIT     0
`define CTMR_MODE_CMP    2'h0
`define CTMR_MODE_PWM    2'h2
`define CTMR_MODE_TMR    2'h3
`define CTMR_FUNC_NONE   2'h0
`define CTMR_FUNC_LOW    2'h1
`define CTMR_FUNC_HIGH   2'h2
`define CTMR_FUNC_TOG    2'h3
`define CTMR_RST_BYTE    8'h00
`define CTMR_RST_WORD    16'h0000
`define CTMR_CNT_MAX     16'hffff
`define CTMR_TICK_DIV    1
`endif

// [rtl/ctmr_pkg.sv]
// Shared types for the compact timer
package ctmr_pkg;
  typedef logic [7:0]  ctmr_byte_t;
  typedef logic [15:0] ctmr_word_t;
  typedef logic [1:0]  ctmr_code_t;
endpackage : ctmr_pkg

// [rtl/ctmr_pin_if.sv]
// Link from the timer core to its output pin stage
`timescale 1ns/1ps
interface ctmr_pin_if;
  import ctmr_pkg::*;
  ctmr_code_t mode;
  ctmr_code_t pin_func;
  logic       init_level;
  logic       invert;
  logic       run_rise;
  logic       a_event;
  logic       pwm_active;
  modport core (output mode, pin_func, init_level, invert, run_rise, a_event, pwm_active);
  modport pin  (input  mode, pin_func, init_level, invert, run_rise, a_event, pwm_active);
endinterface : ctmr_pin_if

// [rtl/ctmr_tick_div.sv]
// Timer clock divider giving a one-cycle tick enable
`timescale 1ns/1ps
`include "ctmr_map.svh"
module ctmr_tick_div
  import ctmr_pkg::*;
#(
  parameter int DIV = `CTMR_TICK_DIV
) (
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic run,
  output logic      tick
);
  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
  logic [W-1:0] div_reg;
  logic [W-1:0] div_next;
  wire          wrap = (div_reg == W'(DIV - 1));
  // Divider held in reset while stopped
  assign div_next = (!run || wrap) ? '0 : div_reg + 1'b1;
  assign tick     = run && wrap;
  always_ff @(posedge mclk) begin
    if (!rst_b) div_reg <= '0;
    else        div_reg <= div_next;
  end
endmodule : ctmr_tick_div

// [rtl/ctmr_pin_out.sv]
// Output pin stage for compare and PWM modes
`timescale 1ns/1ps
`include "ctmr_map.svh"
module ctmr_pin_out
  import ctmr_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst_b,
  ctmr_pin_if.pin   lk,
  output logic      pin_out,
  output logic      pin_drive_b
);
  logic level_reg;
  logic level_next;
  wire  cmp_mode = (lk.mode == `CTMR_MODE_CMP);
  wire  pwm_mode = (lk.mode == `CTMR_MODE_PWM);
  wire  act_level = (lk.pin_func == `CTMR_FUNC_NONE) ? level_reg :
                    (lk.pin_func == `CTMR_FUNC_LOW)  ? 1'b0 :
                    (lk.pin_func == `CTMR_FUNC_HIGH) ? 1'b1 : ~level_reg;
  assign level_next = lk.run_rise ? lk.init_level :
                      (cmp_mode && lk.a_event) ? act_level : level_reg;
  wire  pwm_raw = (lk.pin_func == `CTMR_FUNC_NONE) ? 1'b0 :
                  (lk.pin_func == `CTMR_FUNC_LOW)  ? 1'b1 :
                  (lk.pin_func == `CTMR_FUNC_HIGH) ? lk.pwm_active : 1'b0;
  wire  pwm_level = lk.init_level ? pwm_raw : ~pwm_raw;
  wire  pin_next = cmp_mode ? (level_next ^ lk.invert) :
                   pwm_mode ? (pwm_level ^ lk.invert) : 1'b0;
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      level_reg   <= 1'b0;
      pin_out     <= 1'b0;
      pin_drive_b <= 1'b1;
    end else begin
      level_reg   <= level_next;
      pin_out     <= pin_next;
      pin_drive_b <= !(cmp_mode || pwm_mode);
    end
  end
endmodule : ctmr_pin_out

// [rtl/ctmr_top.sv]
// Compact timer core: registers, counter, comparators
`timescale 1ns/1ps
`include "ctmr_map.svh"
module ctmr_top
  import ctmr_pkg::*;
#(
  parameter int TICK_DIV = `CTMR_TICK_DIV
) (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic      [7:0] rdata,
  output logic            timer_output_pin,
  output logic            timer_output_drive_b,
  output logic            compare_a_flag,
  output logic            compare_p_flag
);
  // Register state
  logic       run_enable_reg;
  ctmr_byte_t ctrl1_reg;
  ctmr_word_t count_reg;
  ctmr_word_t count_next;
  ctmr_word_t compare_a_reg;
  ctmr_word_t compare_a_next;
  ctmr_byte_t compare_p_reg;
  ctmr_byte_t low_buf_reg;
  ctmr_byte_t low_buf_next;
  ctmr_byte_t rdata_next;
  logic       tick;

  // Address decode
  wire wr_ctrl0   = wr_en && (addr == `CTMR_OFF_CTRL0);
  wire wr_ctrl1   = wr_en && (addr == `CTMR_OFF_CTRL1);
  wire wr_cmpa_lo = wr_en && (addr == `CTMR_OFF_CMPA_LO);
  wire wr_cmpa_hi = wr_en && (addr == `CTMR_OFF_CMPA_HI);
  wire wr_cmpp    = wr_en && (addr == `CTMR_OFF_CMPP);
  wire rd_cnt_hi  = rd_en && (addr == `CTMR_OFF_CNT_HI);
  wire rd_cmpa_hi = rd_en && (addr == `CTMR_OFF_CMPA_HI);

  // Control fields
  // mode decode
  wire [1:0] operating_mode_field = ctrl1_reg[7:6];
  wire [1:0] pin_function_field   = ctrl1_reg[5:4];
  wire       output_initial_level = ctrl1_reg[`CTMR_INIT_BIT];
  wire       output_invert        = ctrl1_reg[`CTMR_INV_BIT];
  wire       duty_period_swap     = ctrl1_reg[`CTMR_SWAP_BIT];
  wire       clear_source_select  = ctrl1_reg[`CTMR_CLR_BIT];
  wire       pwm_mode             = (operating_mode_field == `CTMR_MODE_PWM);
  wire       cmp_mode             = (operating_mode_field == `CTMR_MODE_CMP);
  wire       tmr_mode             = (operating_mode_field == `CTMR_MODE_TMR);

  // rising edge of the run bit
  wire run_rise = wr_ctrl0 && wdata[`CTMR_RUN_BIT] && !run_enable_reg;

  ctmr_tick_div #(
    .DIV   (TICK_DIV)
  ) u_tick (
    .mclk  (mclk),
    .rst_b (rst_b),
    .run   (run_enable_reg),
    .tick  (tick)
  );

  // comparator matches
  // P match on the count about to be reached, so the period is P*256
  wire [15:0] count_inc = count_reg + 16'h0001;
  wire a_equal  = (count_reg == compare_a_reg);
  wire p_equal  = (count_inc == {compare_p_reg, 8'h00});
  wire p_zero   = (compare_p_reg == 8'h00);
  wire a_zero   = (compare_a_reg == `CTMR_RST_WORD);
  wire a_hit    = tick && a_equal && !a_zero;
  wire p_hit    = tick && p_equal && !p_zero;

  wire clear_by_a = pwm_mode ? duty_period_swap : clear_source_select;
  wire clr_now    = clear_by_a ? a_hit : p_hit;

  // with P zero the counter wraps at its maximum
  wire overflow = tick && (count_reg == `CTMR_CNT_MAX) && p_zero;

  assign count_next = run_rise ? `CTMR_RST_WORD :
                      clr_now  ? `CTMR_RST_WORD :
                      tick     ? count_reg + 16'h0001 : count_reg;

  // no P flag when A clears outside PWM
  wire p_flag_next = p_hit && (pwm_mode || !clear_source_select);

  wire duty_by_a   = (count_reg < compare_a_reg);
  wire duty_by_p   = p_zero || (count_reg[15:8] < compare_p_reg);
  wire pwm_active  = duty_period_swap ? duty_by_p : duty_by_a;

  assign low_buf_next = wr_cmpa_lo ? wdata :
                        rd_cnt_hi  ? count_reg[7:0] :
                        rd_cmpa_hi ? compare_a_reg[7:0] : low_buf_reg;

  assign compare_a_next = wr_cmpa_hi ? {wdata, low_buf_reg} : compare_a_reg;

  assign rdata_next = !rd_en                         ? `CTMR_RST_BYTE :
                      (addr == `CTMR_OFF_CTRL0)    ? {4'h0, run_enable_reg, 3'h0} :
                      (addr == `CTMR_OFF_CTRL1)    ? ctrl1_reg :
                      (addr == `CTMR_OFF_CNT_LO)   ? low_buf_reg :
                      (addr == `CTMR_OFF_CNT_HI)   ? count_reg[15:8] :
                      (addr == `CTMR_OFF_CMPA_LO)  ? low_buf_reg :
                      (addr == `CTMR_OFF_CMPA_HI)  ? compare_a_reg[15:8] :
                      (addr == `CTMR_OFF_CMPP)     ? compare_p_reg : `CTMR_RST_BYTE;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      run_enable_reg <= 1'b0;
      ctrl1_reg      <= `CTMR_RST_BYTE;
      compare_p_reg  <= `CTMR_RST_BYTE;
    end else begin
      if (wr_ctrl0) run_enable_reg <= wdata[`CTMR_RUN_BIT];
      if (wr_ctrl1) ctrl1_reg <= wdata;
      if (wr_cmpp) compare_p_reg <= wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      count_reg      <= `CTMR_RST_WORD;
      compare_a_reg  <= `CTMR_RST_WORD;
      low_buf_reg    <= `CTMR_RST_BYTE;
      rdata          <= `CTMR_RST_BYTE;
      compare_a_flag <= 1'b0;
      compare_p_flag <= 1'b0;
    end else begin
      count_reg      <= count_next;
      compare_a_reg  <= compare_a_next;
      low_buf_reg    <= low_buf_next;
      rdata          <= rdata_next;
      compare_a_flag <= a_hit;
      compare_p_flag <= p_flag_next;
    end
  end

  // Pin stage link
  ctmr_pin_if pin_lk ();
  assign pin_lk.mode       = operating_mode_field;
  assign pin_lk.pin_func   = pin_function_field;
  assign pin_lk.init_level = output_initial_level;
  assign pin_lk.invert     = output_invert;
  assign pin_lk.run_rise   = run_rise;
  assign pin_lk.a_event    = a_hit;
  assign pin_lk.pwm_active = pwm_active;

  ctmr_pin_out u_pin (
    .mclk        (mclk),
    .rst_b       (rst_b),
    .lk          (pin_lk.pin),
    .pin_out     (timer_output_pin),
    .pin_drive_b (timer_output_drive_b)
  );

  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  a_stop_no_tick: assert property (
    !run_enable_reg |-> !tick
  ) else $error("tick while timer is off");

  a_rise_zero_count: assert property (
    run_rise |=> (count_reg == `CTMR_RST_WORD) && run_enable_reg
  ) else $error("counter not zero after run rise");

  a_stop_hold_count: assert property (
    (!run_enable_reg && !run_rise) |=> $stable(count_reg)
  ) else $error("counter moved while stopped");

  a_ctrl0_low_zero: assert property (
    (rd_en && (addr == `CTMR_OFF_CTRL0)) |=> (rdata[2:0] == 3'h0) && (rdata[7:4] == 4'h0)
  ) else $error("control bits read nonzero");

  a_rise_pin_init: assert property (
    (run_rise && cmp_mode) |=> (timer_output_pin == $past(output_initial_level ^ output_invert))
  ) else $error("pin not at initial level after run rise");

  a_tmr_pin_idle: assert property (
    tmr_mode |=> timer_output_drive_b && !timer_output_pin
  ) else $error("pin driven in timer/counter mode");

  a_cmp_toggle_pin: assert property (
    (cmp_mode && (pin_function_field == `CTMR_FUNC_TOG) && a_hit && !run_rise && $stable(ctrl1_reg))
      |=> (timer_output_pin != $past(timer_output_pin))
  ) else $error("pin did not toggle on compare A");

  a_pwm_force_active: assert property (
    (pwm_mode && (pin_function_field == `CTMR_FUNC_LOW) && !wr_ctrl1)
      |=> (timer_output_pin == $past(output_initial_level ^ output_invert))
  ) else $error("forced PWM active level wrong");

  a_p_clear_count: assert property (
    (p_hit && !pwm_mode && !clear_source_select) |=> (count_reg == `CTMR_RST_WORD)
  ) else $error("compare P did not clear counter");

  a_a_clear_count: assert property (
    (a_hit && !pwm_mode && clear_source_select) |=> (count_reg == `CTMR_RST_WORD) && compare_a_flag
  ) else $error("compare A did not clear counter");

  a_overflow_wrap: assert property (
    (overflow && !run_rise) |=> (count_reg == `CTMR_RST_WORD)
  ) else $error("counter did not wrap on overflow");

  // no P flag when A clears outside PWM
  a_no_p_flag: assert property (
    compare_p_flag |-> $past(pwm_mode || !clear_source_select)
  ) else $error("P flag raised with A clear");

  a_buffer_commit: assert property (
    wr_cmpa_hi |=> (compare_a_reg == {$past(wdata), $past(low_buf_reg)})
  ) else $error("compare A commit wrong");

  a_count_latch: assert property (
    rd_cnt_hi ##1 (rd_en && (addr == `CTMR_OFF_CNT_LO))
      |=> (rdata == $past(count_reg[7:0], 2))
  ) else $error("count low byte not latched");

  a_count_advance: assert property (
    (tick && !clr_now && !run_rise) |=> (count_reg == $past(count_reg) + 16'h0001)
  ) else $error("counter did not advance");

  c_run_rise: cover property (run_rise);
  c_p_period: cover property (p_hit && !pwm_mode);
  c_pwm_period: cover property (pwm_mode && clr_now);
  c_a_toggle: cover property (cmp_mode && a_hit && (pin_function_field == `CTMR_FUNC_TOG));

endmodule : ctmr_top

// [test/ctmr_top_tb.sv]
// Self-checking testbench for the compact timer top
`timescale 1ns/1ps
`include "ctmr_map.svh"
module ctmr_top_tb;
  import ctmr_pkg::*;
  logic       mclk;
  logic       rst_b;
  logic [2:0] addr;
  ctmr_byte_t wdata;
  logic       wr_en;
  logic       rd_en;
  logic [7:0] rdata;
  logic       pin;
  logic       drv_b;
  logic       fa;
  logic       fp;
  int         failures;
  int         samples_checked;

  ctmr_top #(.TICK_DIV(1)) i_dut (
    .mclk                 (mclk),
    .rst_b                (rst_b),
    .addr                 (addr),
    .wdata                (wdata),
    .wr_en                (wr_en),
    .rd_en                (rd_en),
    .rdata                (rdata),
    .timer_output_pin     (pin),
    .timer_output_drive_b (drv_b),
    .compare_a_flag       (fa),
    .compare_p_flag       (fp)
  );

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input ctmr_byte_t d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output ctmr_byte_t d);
    @(posedge mclk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  task automatic wait_flag(input bit use_p, output int n);
    for (n = 1; n <= 1000; n++) begin
      @(posedge mclk);
      #1;
      if ((use_p ? fp : fa) === 1'b1) break;
    end
    if (n > 1000) begin
      failures++;
      $display("BAD flag wait expected 1 seen 0");
      stop_test;
    end
  endtask : wait_flag

  task automatic start(input ctmr_byte_t c);
    wr(`CTMR_OFF_CTRL0, 8'h00);
    wr(`CTMR_OFF_CTRL1, c);
    wr(`CTMR_OFF_CTRL0, 8'h08);
  endtask : start

  task automatic t_regs;
    ctmr_byte_t d;
    for (int a = 0; a < 8; a++) begin
      rd(a[2:0], d);
      chk("reset read", 16'h0000, {8'h00, d});
    end
    wr(`CTMR_OFF_CNT_LO, 8'hff);
    wr(`CTMR_OFF_CNT_HI, 8'hff);
    rd(`CTMR_OFF_CNT_HI, d);
    chk("count high read only", 16'h0000, {8'h00, d});
    wr(`CTMR_OFF_CTRL0, 8'hff);
    rd(`CTMR_OFF_CTRL0, d);
    chk("ctrl0 readback", 16'h0008, {8'h00, d});
    wr(`CTMR_OFF_CTRL0, 8'h00);
    wr(`CTMR_OFF_CTRL1, 8'h5a);
    rd(`CTMR_OFF_CTRL1, d);
    chk("ctrl1 readback", 16'h005a, {8'h00, d});
    chk("undefined mode undriven", 16'h0001, {15'h0000, drv_b});
    wr(`CTMR_OFF_CMPA_LO, 8'h34);
    wr(`CTMR_OFF_CMPA_HI, 8'h12);
    rd(`CTMR_OFF_CMPA_HI, d);
    chk("compare a high", 16'h0012, {8'h00, d});
    rd(`CTMR_OFF_CMPA_LO, d);
    chk("compare a low", 16'h0034, {8'h00, d});
    wr(`CTMR_OFF_CMPP, 8'h02);
    rd(`CTMR_OFF_CMPP, d);
    chk("compare p", 16'h0002, {8'h00, d});
    $display("test regs done");
  endtask : t_regs

  task automatic t_count;
    ctmr_byte_t h1;
    ctmr_byte_t l1;
    ctmr_byte_t h2;
    ctmr_byte_t l2;
    int         n;
    start(8'h00);
    wait_flag(1'b1, n);
    wait_flag(1'b1, n);
    chk("p clear period", 16'd512, n[15:0]);
    wr(`CTMR_OFF_CTRL0, 8'h00);
    rd(`CTMR_OFF_CNT_HI, h1);
    rd(`CTMR_OFF_CNT_LO, l1);
    repeat (5) @(posedge mclk);
    rd(`CTMR_OFF_CNT_HI, h2);
    rd(`CTMR_OFF_CNT_LO, l2);
    chk("held count", {h1, l1}, {h2, l2});
    wr(`CTMR_OFF_CTRL0, 8'h08);
    rd(`CTMR_OFF_CNT_HI, h1);
    rd(`CTMR_OFF_CNT_LO, l1);
    chk("restart high", 16'h0000, {8'h00, h1});
    chk("restart low", 16'h0001, {8'h00, l1});
    $display("test count done");
  endtask : t_count

  task automatic t_cmp;
    logic ini;
    logic ex;
    int   n;
    int   k;
    wr(`CTMR_OFF_CMPP, 8'h01);
    wr(`CTMR_OFF_CMPA_LO, 8'h80);
    wr(`CTMR_OFF_CMPA_HI, 8'h01);
    for (int f = 0; f < 4; f++) begin
      ini = (f == 1);
      ex  = (f == 0) ? ini : (f == 1) ? 1'b0 : (f == 2) ? 1'b1 : !ini;
      start({2'b00, f[1:0], ini, 3'b001});
      repeat (2) @(posedge mclk);
      #1;
      chk("pin initial", {15'h0000, ini}, {15'h0000, pin});
      chk("pin driven", 16'h0000, {15'h0000, drv_b});
      wait_flag(1'b0, n);
      repeat (2) @(posedge mclk);
      #1;
      chk("pin after match", {15'h0000, ex}, {15'h0000, pin});
    end
    wait_flag(1'b0, n);
    wait_flag(1'b0, n);
    chk("a clear period", 16'd385, n[15:0]);
    k = 0;
    repeat (400) begin
      @(posedge mclk);
      #1;
      if (fp === 1'b1) k++;
    end
    chk("no p flag", 16'h0000, k[15:0]);
    start({2'b00, 2'b10, 1'b0, 3'b101});
    repeat (2) @(posedge mclk);
    #1;
    chk("inverted initial", 16'h0001, {15'h0000, pin});
    $display("test compare done");
  endtask : t_cmp

  task automatic t_pwm(input ctmr_byte_t c, input ctmr_word_t a, input int per, input int exp);
    int k;
    wr(`CTMR_OFF_CTRL0, 8'h00);
    wr(`CTMR_OFF_CMPA_LO, a[7:0]);
    wr(`CTMR_OFF_CMPA_HI, a[15:8]);
    start(c);
    repeat (4) @(posedge mclk);
    k = 0;
    repeat (per) begin
      @(posedge mclk);
      #1;
      if (pin === 1'b1) k++;
    end
    chk("pwm high cycles", exp[15:0], k[15:0]);
    $display("test pwm %h done", c);
  endtask : t_pwm

  task automatic t_tmr;
    int n;
    start(8'hc0);
    repeat (2) @(posedge mclk);
    #1;
    chk("timer mode undriven", 16'h0001, {15'h0000, drv_b});
    wait_flag(1'b1, n);
    wait_flag(1'b1, n);
    chk("timer mode period", 16'd256, n[15:0]);
    $display("test timer done");
  endtask : t_tmr

  // P zero: counter wraps at its maximum, A at ffff flags it
  task automatic t_wrap;
    ctmr_byte_t h;
    int         n;
    wr(`CTMR_OFF_CMPP, 8'h00);
    wr(`CTMR_OFF_CMPA_LO, 8'hff);
    wr(`CTMR_OFF_CMPA_HI, 8'hff);
    start(8'hc0);
    for (n = 1; n <= 70000; n++) begin
      @(posedge mclk);
      #1;
      if (fa === 1'b1) break;
    end
    if (n > 70000) begin
      failures++;
      $display("BAD wrap wait expected 1 seen 0");
      stop_test;
    end
    chk("wrap period minus one", 16'hffff, 16'(n - 1));
    rd(`CTMR_OFF_CNT_HI, h);
    chk("wrap high", 16'h0000, {8'h00, h});
    $display("test wrap done");
  endtask : t_wrap

  initial begin
    rst_b           = 1'b0;
    addr            = 3'h0;
    wdata           = 8'h00;
    wr_en           = 1'b0;
    rd_en           = 1'b0;
    failures        = 0;
    samples_checked = 0;
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    t_regs;
    t_count;
    t_cmp;
    t_pwm(8'ha8, 16'h0040, 256, 64);
    t_pwm(8'haa, 16'h01ff, 512, 256);
    t_pwm(8'ha0, 16'h0040, 256, 192);
    t_pwm(8'hac, 16'h0040, 256, 192);
    t_pwm(8'h88, 16'h0040, 256, 0);
    t_pwm(8'h98, 16'h0040, 256, 256);
    t_pwm(8'hb8, 16'h0040, 256, 0);
    t_tmr;
    t_wrap;
    stop_test;
  end
endmodule : ctmr_top_tb
